// ==== hw/dcc_pkg.sv ====
// Constants shared by the comparator change-detection block.
// Assumes one 125 MHz clock and a single-cycle register port.
// How it works
// - Change flag sets whenever either comparator result differs from the held value.
// - A held latch captures comparator outputs on every config register read.
// - A second latch samples live outputs each phase_one; mismatch flows from it.
// - Mismatch persists until config read or output returns to held value.
// - A config register write also refreshes the held latch, ending mismatch.
// - Flag clears only by writing zero; writing one sets it.
// - Interrupt needs comparator, peripheral and global enables all set.
// - Clearing the flag fails while a mismatch persists.
// - A change coincident with a config read may not set the flag.
// - Result bits 7 and 6 show comparator outputs, inverted by bits 5 and 4.
// - Port reads return zero for every pin configured analog.
package dcc_pkg;
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_FLAG = 4'h1;
  localparam logic [3:0] ADDR_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_IRQCTL = 4'h3;
  localparam logic [3:0] ADDR_PORT = 4'h4;
  localparam logic [3:0] ADDR_ANSEL = 4'h5;
  localparam int BIT_B_RESULT = 7;
  localparam int BIT_A_RESULT = 6;
  localparam int BIT_B_POL = 5;
  localparam int BIT_A_POL = 4;
  localparam int BIT_FLAG = 0;
  localparam int BIT_GIE = 1;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] ANSEL_RESET = 8'hff;
  localparam logic [2:0] MODE_OFF = 3'h7;
  localparam logic [2:0] MODE_COMMON_REF = 3'h3;
  localparam logic [2:0] MODE_RESET_OFF = 3'h0;
  localparam logic [1:0] PHASE_COUNT = 2'h3;
  localparam logic [1:0] PHASE_ONE = 2'h0;
endpackage

// ==== hw/dcc_phase_gen.sv ====
// Four-phase instruction cycle generator.
// Assumes synchronous active-high reset.
`timescale 1ns/1ps
module dcc_phase_gen (
  input wire logic clk_sys,
  input wire logic reset,
  output logic phaseOne
);
  logic [1:0] phase;
  logic [1:0] next_phase;

  // Free-running phase counter
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase <= dcc_pkg::PHASE_COUNT;
    end else begin
      phase <= next_phase;
    end
  end

  assign phaseOne = (phase == dcc_pkg::PHASE_ONE);
endmodule

// ==== hw/dcc_mismatch.sv ====
// Two-latch mismatch detector for both comparators.
// Assumes comparator outputs are synchronous to clk_sys.
`timescale 1ns/1ps
module dcc_mismatch (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic phaseOne,
  input wire logic capture,
  input wire logic [1:0] cmpLive,
  output logic mismatch
);
  logic [1:0] held;
  logic [1:0] sampled;
  logic [1:0] next_held;
  logic [1:0] next_sampled;

  // Any config access reloads both latches, so the access ends a stale mismatch at once
  // Limitation: a change landing on the access edge is absorbed and never flagged
  always_comb begin
    next_held = capture ? cmpLive : held;
    next_sampled = (phaseOne || capture) ? cmpLive : sampled;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      held <= 2'h0;
      sampled <= 2'h0;
    end else begin
      held <= next_held;
      sampled <= next_sampled;
    end
  end

  // Either direction of change counts; returning ends it
  assign mismatch = |(held ^ sampled);
endmodule

// ==== hw/dcc_top.sv ====
// Comparator configuration, change flag and interrupt chain.
// Assumes a single-cycle register port; read data one cycle later.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module dcc_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic cmpARaw,
  input wire logic cmpBRaw,
  input wire logic [7:0] portPins,
  output logic [2:0] comparator_config_select,
  output logic input_switch_select,
  output logic cmpAEnable,
  output logic cmpBEnable,
  output logic commonReference,
  output logic irq
);
  logic [7:0] configReg;
  logic [7:0] next_configReg;
  logic changeFlag;
  logic next_changeFlag;
  logic irqEnable;
  logic next_irqEnable;
  logic globalEnable;
  logic next_globalEnable;
  logic periphEnable;
  logic next_periphEnable;
  logic [7:0] analogSel;
  logic [7:0] next_analogSel;
  logic [7:0] next_regRdData;
  logic phaseOne;
  logic mismatch;
  logic cfgAccess;
  logic cmpAResult;
  logic cmpBResult;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  dcc_phase_gen u_phase (
    .clk_sys(clk_sys),
    .reset(reset),
    .phaseOne(phaseOne)
  );

  // Polarity bits invert the visible result
  assign cmpAResult = cmpARaw ^ configReg[dcc_pkg::BIT_A_POL];
  assign cmpBResult = cmpBRaw ^ configReg[dcc_pkg::BIT_B_POL];

  // A write includes an internal read, so both refresh the held latch
  assign cfgAccess = (regRead || regWrite) && hit(regAddr, dcc_pkg::ADDR_CONFIG);

  dcc_mismatch u_mm (
    .clk_sys(clk_sys),
    .reset(reset),
    .phaseOne(phaseOne),
    .capture(cfgAccess),
    .cmpLive({cmpBResult, cmpARaw ^ configReg[dcc_pkg::BIT_A_POL]}),
    .mismatch(mismatch)
  );

  // Mode decode; reset mode and off mode disable both comparators
  assign comparator_config_select = configReg[2:0];
  assign input_switch_select = configReg[3];
  assign cmpAEnable = (configReg[2:0] != dcc_pkg::MODE_OFF)
                      && (configReg[2:0] != dcc_pkg::MODE_RESET_OFF);
  assign cmpBEnable = cmpAEnable;
  assign commonReference = (configReg[2:0] == dcc_pkg::MODE_COMMON_REF);

  // Register writes; result bits are not writable
  always_comb begin
    next_configReg = configReg;
    next_irqEnable = irqEnable;
    next_globalEnable = globalEnable;
    next_periphEnable = periphEnable;
    next_analogSel = analogSel;
    if (regWrite) begin
      if (hit(regAddr, dcc_pkg::ADDR_CONFIG)) begin
        next_configReg = {2'h0, regWrData[5:0]};
      end else if (hit(regAddr, dcc_pkg::ADDR_ENABLE)) begin
        next_irqEnable = regWrData[dcc_pkg::BIT_FLAG];
      end else if (hit(regAddr, dcc_pkg::ADDR_IRQCTL)) begin
        next_globalEnable = regWrData[dcc_pkg::BIT_GIE];
        next_periphEnable = regWrData[dcc_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
      end else if (hit(regAddr, dcc_pkg::ADDR_ANSEL)) begin
        next_analogSel = regWrData;
      end
    end
  end

  // Set wins over clear; a live mismatch keeps the flag high
  always_comb begin
    next_changeFlag = changeFlag;
    if (regWrite && hit(regAddr, dcc_pkg::ADDR_FLAG)) begin
      next_changeFlag = regWrData[dcc_pkg::BIT_FLAG];
    end
    if (mismatch) begin
      next_changeFlag = 1'b1;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_regRdData = 8'h00;
    if (regRead) begin
      if (hit(regAddr, dcc_pkg::ADDR_CONFIG)) begin
        next_regRdData = {cmpBResult, cmpAResult, configReg[5:0]};
      end else if (hit(regAddr, dcc_pkg::ADDR_FLAG)) begin
        next_regRdData = {7'h00, changeFlag};
      end else if (hit(regAddr, dcc_pkg::ADDR_ENABLE)) begin
        next_regRdData = {7'h00, irqEnable};
      end else if (hit(regAddr, dcc_pkg::ADDR_IRQCTL)) begin
        next_regRdData = {6'h00, globalEnable, periphEnable};
      end else if (hit(regAddr, dcc_pkg::ADDR_PORT)) begin
        next_regRdData = portPins & ~analogSel;
      end else if (hit(regAddr, dcc_pkg::ADDR_ANSEL)) begin
        next_regRdData = analogSel;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      configReg <= dcc_pkg::CONFIG_RESET;
      changeFlag <= 1'b0;
      irqEnable <= 1'b0;
      globalEnable <= 1'b0;
      periphEnable <= 1'b0;
      analogSel <= dcc_pkg::ANSEL_RESET;
      regRdData <= 8'h00;
    end else begin
      configReg <= next_configReg;
      changeFlag <= next_changeFlag;
      irqEnable <= next_irqEnable;
      globalEnable <= next_globalEnable;
      periphEnable <= next_periphEnable;
      analogSel <= next_analogSel;
      regRdData <= next_regRdData;
    end
  end

  // All three enables gate the level interrupt; flag sets regardless
  assign irq = changeFlag && irqEnable && periphEnable && globalEnable;

  flag_on_mismatch_a: assert property (@(posedge clk_sys) disable iff (reset)
    mismatch |=> changeFlag) else $error("flag not held by mismatch");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrite && hit(regAddr, dcc_pkg::ADDR_FLAG) && regWrData[dcc_pkg::BIT_FLAG]
    && irqEnable && periphEnable && globalEnable) |=> irq)
    else $error("interrupt gating wrong");
  irq_masked_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(irqEnable && periphEnable && globalEnable) |-> !irq)
    else $error("masked interrupt raised");
  clear_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrite && hit(regAddr, dcc_pkg::ADDR_FLAG) && !regWrData[0] && !mismatch)
    |=> !changeFlag) else $error("flag clear failed");
  set_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (regWrite && hit(regAddr, dcc_pkg::ADDR_FLAG) && regWrData[0]) |=> changeFlag)
    else $error("flag set failed");
  result_ro_a: assert property (@(posedge clk_sys) disable iff (reset)
    configReg[7:6] == 2'h0) else $error("result bits stored");
  port_analog_a: assert property (@(posedge clk_sys) disable iff (reset)
    (regRead && hit(regAddr, dcc_pkg::ADDR_PORT)) |=> ((regRdData & $past(analogSel)) == 8'h00))
    else $error("analog pin read nonzero");
  change_sets_a: assert property (@(posedge clk_sys) disable iff (reset)
    ($changed({cmpBResult, cmpAResult}) && !cfgAccess && !regWrite)
    ##1 (!cfgAccess && !regWrite)[*5] |-> changeFlag) else $error("change missed");
  polarity_a: assert property (@(posedge clk_sys) disable iff (reset)
    (regRead && hit(regAddr, dcc_pkg::ADDR_CONFIG)) |=>
    regRdData[7] == ($past(cmpBRaw) ^ $past(configReg[5]))) else $error("polarity wrong");
  access_ends_a: assert property (@(posedge clk_sys) disable iff (reset)
    (cfgAccess && $stable(cmpARaw) && $stable(cmpBRaw)) ##1 ($stable(cmpARaw)
    && $stable(cmpBRaw) && !$changed(configReg[5:4])) |-> !mismatch)
    else $error("access kept mismatch");
  irq_cover_c: cover property (@(posedge clk_sys) irq);
  clear_cover_c: cover property (@(posedge clk_sys) changeFlag ##1 !changeFlag);
  mm_cover_c: cover property (@(posedge clk_sys) mismatch ##1 !mismatch);
endmodule

// ==== test/dcc_core_model.sv ====
// Processor core model: issues single-cycle register reads and writes.
// Assumes one caller at a time and the one-cycle read latency of the port.
`timescale 1ns/1ps
module dcc_core_model (
  input wire logic clk_sys,
  output logic [3:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData
);
  // Own copy of the last result, since the flag cannot say which way it went
  logic [7:0] lastCfg;
  initial begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    lastCfg = 8'h00;
  end
  // Strobe for one cycle; data inverted once released so no stale value lingers
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    regAddr <= addr;
    regWrData <= data;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWrData <= ~data;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    regAddr <= addr;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    data = regRdData;
    if (addr == dcc_pkg::ADDR_CONFIG) lastCfg = data;
  endtask
  // Handler order: end the mismatch first, then clear the flag
  task automatic service();
    logic [7:0] d;
    rd(dcc_pkg::ADDR_CONFIG, d);
    wr(dcc_pkg::ADDR_FLAG, 8'h00);
  endtask
endmodule

// ==== test/dcc_tb_top.sv ====
// Self-checking bench for the comparator change-detection block.
// Assumes the core model drives the register port; bench drives pins.
`timescale 1ns/1ps
module dcc_tb_top;
  logic clk_sys, reset, cmpARaw, cmpBRaw, regWrite, regRead, irq;
  logic input_switch_select, cmpAEnable, cmpBEnable, commonReference;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, portPins, d, cfg, ansel;
  logic [2:0] comparator_config_select;
  int mismatches, samplesChecked, cycles, seed, k;
  dcc_top dcc_top_i (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .cmpARaw(cmpARaw), .cmpBRaw(cmpBRaw), .portPins(portPins),
    .comparator_config_select(comparator_config_select),
    .input_switch_select(input_switch_select), .cmpAEnable(cmpAEnable),
    .cmpBEnable(cmpBEnable), .commonReference(commonReference), .irq(irq));
  dcc_core_model dcc_core_model_i (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  always #4 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] expCfg(input logic [7:0] c, input logic a, input logic b);
    return {b ^ c[5], a ^ c[4], c[5:0]};
  endfunction
  function automatic logic [7:0] expDecode(input logic [7:0] c);
    logic on;
    on = (c[2:0] != dcc_pkg::MODE_RESET_OFF) && (c[2:0] != dcc_pkg::MODE_OFF);
    return {1'b0, c[2:0] == dcc_pkg::MODE_COMMON_REF, on, on, c[3:0]};
  endfunction
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    clk_sys = 1'b0;
    cmpARaw = 1'b0;
    cmpBRaw = 1'b0;
    portPins = 8'hff;
    seed = 89;
    reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    dcc_core_model_i.rd(dcc_pkg::ADDR_CONFIG, d);
    check("config reset", d, dcc_pkg::CONFIG_RESET);
    dcc_core_model_i.rd(dcc_pkg::ADDR_PORT, d);
    check("port all analog", d, 8'h00);
    dcc_core_model_i.rd(4'hf, d);
    check("unmapped read", d, 8'h00);
    // Random config and comparator levels; every mode visited
    for (k = 0; k < 24; k++) begin
      cfg = {$random(seed)} % 256;
      cfg[2:0] = k[2:0];
      cmpARaw <= $random(seed);
      cmpBRaw <= $random(seed);
      dcc_core_model_i.wr(dcc_pkg::ADDR_CONFIG, cfg);
      dcc_core_model_i.rd(dcc_pkg::ADDR_CONFIG, d);
      check("config readback", d, expCfg(cfg, cmpARaw, cmpBRaw));
      check("mode decode", {1'b0, commonReference, cmpBEnable, cmpAEnable,
        input_switch_select, comparator_config_select}, expDecode(cfg));
      ansel = {$random(seed)} % 256;
      portPins <= $random(seed);
      dcc_core_model_i.wr(dcc_pkg::ADDR_ANSEL, ansel);
      dcc_core_model_i.rd(dcc_pkg::ADDR_PORT, d);
      check("port read", d, portPins & ~ansel);
    end
    // Quiet start: no polarity, wait out response time, then service
    cmpARaw <= 1'b0;
    cmpBRaw <= 1'b0;
    dcc_core_model_i.wr(dcc_pkg::ADDR_CONFIG, 8'h00);
    repeat (8) @(posedge clk_sys);
    dcc_core_model_i.service();
    // Each comparator, both directions; write ends mismatch in last two
    for (k = 0; k < 4; k++) begin
      if (k[0]) cmpBRaw <= ~cmpBRaw;
      else cmpARaw <= ~cmpARaw;
      repeat (8) @(posedge clk_sys);
      dcc_core_model_i.rd(dcc_pkg::ADDR_FLAG, d);
      check("flag on change", d, 8'h01);
      dcc_core_model_i.wr(dcc_pkg::ADDR_FLAG, 8'h00);
      dcc_core_model_i.rd(dcc_pkg::ADDR_FLAG, d);
      check("clear in mismatch", d, 8'h01);
      if (k < 2) begin
        dcc_core_model_i.service();
        check("own record", {6'h00, dcc_core_model_i.lastCfg[7:6]},
          {6'h00, cmpBRaw, cmpARaw});
      end else begin
        dcc_core_model_i.wr(dcc_pkg::ADDR_CONFIG, 8'h00);
      end
      dcc_core_model_i.wr(dcc_pkg::ADDR_FLAG, 8'h00);
      dcc_core_model_i.rd(dcc_pkg::ADDR_FLAG, d);
      check("flag serviced", d, 8'h00);
    end
    // Output returns to held state: mismatch ends without any access
    cmpARaw <= 1'b1;
    repeat (8) @(posedge clk_sys);
    cmpARaw <= 1'b0;
    repeat (8) @(posedge clk_sys);
    dcc_core_model_i.rd(dcc_pkg::ADDR_FLAG, d);
    check("flag sticky after return", d, 8'h01);
    dcc_core_model_i.wr(dcc_pkg::ADDR_FLAG, 8'h00);
    dcc_core_model_i.rd(dcc_pkg::ADDR_FLAG, d);
    check("flag after return", d, 8'h00);
    // All enable combinations with a software-set flag
    for (k = 0; k < 8; k++) begin
      dcc_core_model_i.wr(dcc_pkg::ADDR_FLAG, 8'h01);
      dcc_core_model_i.wr(dcc_pkg::ADDR_ENABLE, {7'h00, k[0]});
      dcc_core_model_i.wr(dcc_pkg::ADDR_IRQCTL, {6'h00, k[2:1]});
      @(posedge clk_sys);
      #1;
      check("irq gating", {7'h00, irq}, {7'h00, &k[2:0]});
    end
    dcc_core_model_i.wr(dcc_pkg::ADDR_FLAG, 8'h00);
    @(posedge clk_sys);
    #1;
    check("irq after clear", {7'h00, irq}, 8'h00);
    dcc_core_model_i.wr(dcc_pkg::ADDR_FLAG, 8'h01);
    @(posedge clk_sys);
    #1;
    check("irq on software set", {7'h00, irq}, 8'h01);
    // Second reset in mid-run restores the config register
    dcc_core_model_i.wr(dcc_pkg::ADDR_CONFIG, 8'h3f);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    dcc_core_model_i.rd(dcc_pkg::ADDR_CONFIG, d);
    check("config after reset", d, dcc_pkg::CONFIG_RESET);
    report_and_stop();
  end
endmodule
